// >>> rtl/gpt_pkg.sv
package gpt_pkg;

  // ----------------------------------------
  // Register offsets (word index on reg_addr)
  // ----------------------------------------
  localparam int GPT_AW = 4;
  localparam logic [3:0] GPT_OFS_PCTL = 4'h0;
  localparam logic [3:0] GPT_OFS_PCNT = 4'h1;
  localparam logic [3:0] GPT_OFS_PPER = 4'h2;
  localparam logic [3:0] GPT_OFS_ECTL = 4'h3;
  localparam logic [3:0] GPT_OFS_OCTL = 4'h4;
  localparam logic [3:0] GPT_OFS_ECNT = 4'h5;
  localparam logic [3:0] GPT_OFS_OCNT = 4'h6;
  localparam logic [3:0] GPT_OFS_EPER = 4'h7;
  localparam logic [3:0] GPT_OFS_OPER = 4'h8;
  localparam logic [3:0] GPT_OFS_FLAG = 4'h9;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int GPT_B_RUN = 15;
  localparam int GPT_B_IDLE = 13;
  localparam int GPT_B_GATE = 6;
  localparam int GPT_B_PS_HI = 5;
  localparam int GPT_B_PS_LO = 4;
  localparam int GPT_B_WIDE = 3;
  localparam int GPT_B_SYNC = 2;
  localparam int GPT_B_CS = 1;

  // Writable bits of each control register
  localparam logic [15:0] GPT_MASK_P = 16'ha076;
  localparam logic [15:0] GPT_MASK_E = 16'ha07a;
  localparam logic [15:0] GPT_MASK_O = 16'ha072;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] GPT_CTL_RST = 16'h0000;
  localparam logic [15:0] GPT_CNT_RST = 16'h0000;
  localparam logic [15:0] GPT_PER_RST = 16'hffff;
  localparam logic [7:0] GPT_PRE_RST = 8'h00;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] GPT_PS_T1 = 8'h00;
  localparam logic [7:0] GPT_PS_T8 = 8'h07;
  localparam logic [7:0] GPT_PS_T64 = 8'h3f;
  localparam logic [7:0] GPT_PS_T256 = 8'hff;

endpackage

// >>> rtl/gpt_timers.sv
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Primary 16-bit timer, sync or async counter
// - Primary flag on period match or gate fall
// - Run bit 15 starts and stops timer
// - Idle-halt bit 13 stops timer in Idle
// - Gate accumulate bit 6, internal clock only
// - Prescale bits 5-4: 1, 8, 64, 256
// - Sync bit 2 matters only for external clock
// - Clock source: external rising edge or internal
// - Control write while running clears prescaler
// - Unimplemented control bits read zero
// - Async primary keeps counting in Sleep
// - Pair: two 16-bit or one 32-bit
// - Wide bit 3 of even control cascades pair
// - Wide mode uses even control, odd flag
// - Odd period high word, even low word
// - Odd count high word, even low word
// - ADC trigger: pair wide, odd when narrow
module gpt_timers
  import gpt_pkg::*;
#(
  parameter int AW = GPT_AW
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  input wire logic primary_ext_clock_pin,
  input wire logic even_ext_clock_pin,
  input wire logic odd_ext_clock_pin,
  output logic primary_flag,
  output logic even_flag,
  output logic odd_flag,
  output logic adc_trigger
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Prescaler terminal count from the select field
  // Counts N-1 pulses then wraps, giving a divide by N
  function automatic logic [7:0] ps_term(input logic [1:0] sel);
    logic [7:0] t;
    t = GPT_PS_T1;
    case (sel)
      2'b01: t = GPT_PS_T8;
      2'b10: t = GPT_PS_T64;
      2'b11: t = GPT_PS_T256;
      default: t = GPT_PS_T1;
    endcase
    return t;
  endfunction

  // Address match qualified by a strobe
  function automatic logic hit(input logic stb,
                               input logic [AW-1:0] a,
                               input logic [3:0] ofs);
    return stb && (a == AW'(ofs));
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Control words hold only their writable bits, so a read returns
  // zero in every unimplemented position without extra masking.
  // Periods reset to all ones so an idle timer never matches early.
  // Index 0 primary, 1 even, 2 odd
  logic [15:0] ctl_r [3];
  logic [15:0] cnt_r [3];
  logic [15:0] per_r [3];
  logic [7:0] pre_r [3];
  logic [2:0] s1_r, s2_r, s3_r, lvl_r;
  logic [2:0] flag_r;
  logic [15:0] rdata_r;
  logic adc_r;

  // Combinational decode and next values
  logic [2:0] pin_in;
  logic [2:0] wr_ctl, wr_cnt, wr_per;
  logic [2:0] tick, m16, gfall;
  logic [15:0] cnt_nxt [3];
  logic [2:0] cnt_en;
  logic wide, m32, wr_flag;
  logic [31:0] cnt32, per32, inc32;
  logic [2:0] flag_set, flag_clr, flag_nxt;
  logic [15:0] rd_mux;

  // Bit 0 primary, bit 1 even, bit 2 odd
  assign pin_in = {odd_ext_clock_pin, even_ext_clock_pin,
                   primary_ext_clock_pin};

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Unmapped addresses hit nothing, so writes there are dropped
  // Write strobes per register
  assign wr_ctl = {hit(reg_wr, reg_addr, GPT_OFS_OCTL),
                   hit(reg_wr, reg_addr, GPT_OFS_ECTL),
                   hit(reg_wr, reg_addr, GPT_OFS_PCTL)};
  assign wr_cnt = {hit(reg_wr, reg_addr, GPT_OFS_OCNT),
                   hit(reg_wr, reg_addr, GPT_OFS_ECNT),
                   hit(reg_wr, reg_addr, GPT_OFS_PCNT)};
  assign wr_per = {hit(reg_wr, reg_addr, GPT_OFS_OPER),
                   hit(reg_wr, reg_addr, GPT_OFS_EPER),
                   hit(reg_wr, reg_addr, GPT_OFS_PPER)};
  assign wr_flag = hit(reg_wr, reg_addr, GPT_OFS_FLAG);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages; a level counts when stages two and three agree
  // The first stage may go metastable; only the second stage reads it.
  // Requiring stages two and three to agree filters one-cycle
  // glitches, at the cost of about four cycles of latency.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accepted pin level
  // Holds the last agreed level; edges are detected against it.
  // Resets low like an idle pin, so no false edge follows reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      lvl_r <= 3'h0;
    end else begin
      lvl_r <= (s2_r ~^ s3_r) & s3_r | ~(s2_r ~^ s3_r) & lvl_r;
    end
  end

  // ----------------------------------------
  // Per-timer clocking and registers
  // ----------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_tmr
    logic [15:0] c;
    logic [15:0] mask;
    logic chg, rise, fall, gmode, asyn, run, src, step;

    assign c = ctl_r[i];
    assign mask = (i == 0) ? GPT_MASK_P :
                  (i == 1) ? GPT_MASK_E : GPT_MASK_O;
    assign chg = (s2_r[i] == s3_r[i]) && (s3_r[i] != lvl_r[i]);
    assign rise = chg & s3_r[i];
    assign fall = chg & ~s3_r[i];
    // Gating only with the internal clock
    assign gmode = c[GPT_B_GATE] & ~c[GPT_B_CS];
    // Only the primary timer has the unsynchronised path
    assign asyn = (i == 0) & c[GPT_B_CS] & ~c[GPT_B_SYNC];
    // Sleep stops every timer except an unsynchronised primary
    assign run = c[GPT_B_RUN]
                 & ~(idle_mode & c[GPT_B_IDLE])
                 & ~(sleep_mode & ~asyn);
    // Source pulse: pin rising edge, gate level or every mclk
    assign src = c[GPT_B_CS] ? rise
                 : (gmode ? lvl_r[i] : 1'b1);
    assign step = run & src;
    assign tick[i] = step
                     & (pre_r[i] ==
                        ps_term(c[GPT_B_PS_HI:GPT_B_PS_LO]));
    assign gfall[i] = run & gmode & fall;
    assign m16[i] = tick[i] & (cnt_r[i] == per_r[i]);

    // Prescaler
    // A control write while running restarts the division, so the
    // first tick after a rewrite comes a full prescale period later.
    // The old run bit decides; starting a stopped timer keeps it.
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        pre_r[i] <= GPT_PRE_RST;
      end else if (wr_ctl[i] && c[GPT_B_RUN]) begin
        pre_r[i] <= GPT_PRE_RST;
      end else if (step) begin
        pre_r[i] <= tick[i] ? GPT_PRE_RST : pre_r[i] + 8'h01;
      end
    end

    // Control, period and count registers
    // A software count write overrides a tick in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        ctl_r[i] <= GPT_CTL_RST;
        per_r[i] <= GPT_PER_RST;
        cnt_r[i] <= GPT_CNT_RST;
      end else begin
        if (wr_ctl[i]) begin
          ctl_r[i] <= reg_wdata & mask;
        end
        if (wr_per[i]) begin
          per_r[i] <= reg_wdata;
        end
        if (wr_cnt[i]) begin
          cnt_r[i] <= reg_wdata;
        end else if (cnt_en[i]) begin
          cnt_r[i] <= cnt_nxt[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Pair cascade
  // ----------------------------------------
  // In wide mode the even timer's control word, prescaler and pin
  // drive both halves; the odd control word is stored and readable
  // but has no effect until the pair is split again.
  // The 32-bit compare uses both period halves, so software should
  // load them before setting the run bit.
  // Odd word high, even word low
  assign wide = ctl_r[1][GPT_B_WIDE];
  assign cnt32 = {cnt_r[2], cnt_r[1]};
  assign per32 = {per_r[2], per_r[1]};
  assign inc32 = cnt32 + 32'h0000_0001;
  // Wide mode runs off the even timer's tick alone
  assign m32 = tick[1] & (cnt32 == per32);

  // Count next values and enables
  // Halves are read separately and may tear while the pair runs
  assign cnt_en[0] = tick[0];
  assign cnt_nxt[0] = m16[0] ? GPT_CNT_RST : cnt_r[0] + 16'h0001;
  assign cnt_en[1] = tick[1];
  assign cnt_nxt[1] = wide ? (m32 ? GPT_CNT_RST : inc32[15:0])
                    : (m16[1] ? GPT_CNT_RST : cnt_r[1] + 16'h0001);
  assign cnt_en[2] = wide ? tick[1] : tick[2];
  assign cnt_nxt[2] = wide ? (m32 ? GPT_CNT_RST : inc32[31:16])
                    : (m16[2] ? GPT_CNT_RST : cnt_r[2] + 16'h0001);

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  // A clearing write and a new event in one cycle keep the flag set,
  // so no event is lost to a late clear.
  // The converter trigger is a one-cycle pulse one cycle after the
  // match, from the pair in wide mode and the odd half otherwise.
  // Wide-mode events land on the odd flag; set beats clear
  assign flag_set[0] = m16[0] | gfall[0];
  assign flag_set[1] = ~wide & (m16[1] | gfall[1]);
  assign flag_set[2] = wide ? (m32 | gfall[1])
                       : (m16[2] | gfall[2]);
  assign flag_clr = wr_flag ? reg_wdata[2:0] : 3'h0;
  assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= 3'h0;
      adc_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      adc_r <= wide ? m32 : m16[2];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped addresses read zero
  // The mux follows the address every cycle; the strobe only decides
  // whether its value is captured, keeping reg_rdata zero otherwise.
  assign rd_mux =
    (reg_addr == AW'(GPT_OFS_PCTL)) ? ctl_r[0] :
    (reg_addr == AW'(GPT_OFS_PCNT)) ? cnt_r[0] :
    (reg_addr == AW'(GPT_OFS_PPER)) ? per_r[0] :
    (reg_addr == AW'(GPT_OFS_ECTL)) ? ctl_r[1] :
    (reg_addr == AW'(GPT_OFS_OCTL)) ? ctl_r[2] :
    (reg_addr == AW'(GPT_OFS_ECNT)) ? cnt_r[1] :
    (reg_addr == AW'(GPT_OFS_OCNT)) ? cnt_r[2] :
    (reg_addr == AW'(GPT_OFS_EPER)) ? per_r[1] :
    (reg_addr == AW'(GPT_OFS_OPER)) ? per_r[2] :
    (reg_addr == AW'(GPT_OFS_FLAG)) ? {13'h0, flag_r} :
    16'h0000;

  // Read data valid the cycle after the strobe only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Outputs straight from their flip-flops
  assign reg_rdata = rdata_r;
  assign primary_flag = flag_r[0];
  assign even_flag = flag_r[1];
  assign odd_flag = flag_r[2];
  assign adc_trigger = adc_r;

endmodule

// >>> verification/gpt_pin_model.sv
`timescale 1ns/1ps
module gpt_pin_model (
  input wire logic clk_on,
  input wire logic level,
  output logic pin
);
  // Clock pin runs only in bursts, else holds the level
  initial begin
    pin = 1'b0;
    // Odd offset keeps pin changes away from the sampling edges
    #1;
    forever begin
      #20;
      pin = clk_on ? ~pin : level;
    end
  end
endmodule

// >>> verification/gpt_timers_properties.sv
`timescale 1ns/1ps
module gpt_timers_checker
  import gpt_pkg::*;
#(
  parameter int AW = GPT_AW
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic primary_flag,
  input wire logic even_flag,
  input wire logic odd_flag,
  input wire logic adc_trigger
);
  logic [15:0] pctl_r;
  logic [15:0] ectl_r;
  // Flag register written
  wire fw = reg_wr && reg_addr == GPT_OFS_FLAG;
  // Mirrors of control registers as software wrote them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pctl_r <= 16'h0000;
    end else if (reg_wr && reg_addr == GPT_OFS_PCTL) begin
      pctl_r <= reg_wdata;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ectl_r <= 16'h0000;
    end else if (reg_wr && reg_addr == GPT_OFS_ECTL) begin
      ectl_r <= reg_wdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_pctl_readback: assert property (
    $past(reg_rd && reg_addr == GPT_OFS_PCTL)
    |-> reg_rdata == (pctl_r & GPT_MASK_P)) else $error("pctl readback");
  a_ectl_readback: assert property (
    $past(reg_rd && reg_addr == GPT_OFS_ECTL)
    |-> reg_rdata == (ectl_r & GPT_MASK_E)) else $error("ectl readback");
  a_pflag_hold: assert property (
    primary_flag && !(fw && reg_wdata[0]) |=> primary_flag)
    else $error("primary flag lost");
  a_oflag_hold: assert property (
    odd_flag && !(fw && reg_wdata[2]) |=> odd_flag)
    else $error("odd flag lost");
  a_adc_with_flag: assert property (
    adc_trigger |-> odd_flag) else $error("adc without odd flag");
  a_even_wide_quiet: assert property (
    ectl_r[GPT_B_WIDE] && $past(ectl_r[GPT_B_WIDE]) && !even_flag
    |=> !even_flag) else $error("even flag in wide mode");
  a_stop_quiet: assert property (
    !pctl_r[GPT_B_RUN] && !$past(pctl_r[GPT_B_RUN]) && !primary_flag
    |=> !primary_flag) else $error("flag while stopped");
  a_sleep_still: assert property (
    sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2)
    |-> !$rose(odd_flag)) else $error("odd flag in sleep");
endmodule
bind gpt_timers gpt_timers_checker #(.AW(AW)) chk_i (.mclk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_mode,
  .primary_flag, .even_flag, .odd_flag, .adc_trigger);

// >>> verification/tb_general_purpose_timers.sv
`timescale 1ns/1ps
module tb_general_purpose_timers;
  import gpt_pkg::*;
  logic mclk;
  logic resetn;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic idle_mode;
  logic sleep_mode;
  logic clk_on;
  logic level;
  logic ppin;
  logic primary_flag;
  logic even_flag;
  logic odd_flag;
  logic adc_trigger;
  logic [15:0] v;
  logic [15:0] w;
  int err_count;
  int comparisons;
  int n;
  int dv [4] = '{1, 8, 64, 256};
  logic [3:0] ofs [3] = '{GPT_OFS_PCTL, GPT_OFS_ECTL, GPT_OFS_OCTL};
  logic [15:0] msk [3] = '{GPT_MASK_P, GPT_MASK_E, GPT_MASK_O};
  gpt_timers uut (.mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .idle_mode, .sleep_mode, .primary_ext_clock_pin(ppin),
    .even_ext_clock_pin(ppin), .odd_ext_clock_pin(ppin), .primary_flag,
    .even_flag, .odd_flag, .adc_trigger);
  gpt_pin_model pins (.clk_on, .level, .pin(ppin));
  // Register bus cycles and result checks
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_in(input logic [15:0] g, lo, hi);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  // Cycles until the next trigger pulse
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge mclk);
      c++;
    end while (adc_trigger !== 1'b1 && c < 500);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  // Test sequence
  initial begin
    {resetn, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {idle_mode, sleep_mode, clk_on, level, err_count, comparisons} = '0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], 16'hffff);
      rd(ofs[i], v);
      chk(v, msk[i]);
      wr(ofs[i], 16'h0000);
    end
    $display("masks done");
    for (int p = 0; p < 4; p++) begin
      wr(GPT_OFS_PCNT, 16'h0000);
      wr(GPT_OFS_PCTL, 16'h8000 | 16'(p << 4));
      repeat (8 * dv[p]) @(posedge mclk);
      wr(GPT_OFS_PCTL, 16'h0000);
      rd(GPT_OFS_PCNT, v);
      chk_in(v, 16'd8, 16'd10);
    end
    $display("prescale done");
    idle_mode <= 1'b1;
    wr(GPT_OFS_PCNT, 16'h0000);
    wr(GPT_OFS_PCTL, 16'ha000);
    repeat (20) @(posedge mclk);
    rd(GPT_OFS_PCNT, w);
    wr(GPT_OFS_PCTL, 16'h8000);
    repeat (20) @(posedge mclk);
    wr(GPT_OFS_PCTL, 16'h0000);
    rd(GPT_OFS_PCNT, v);
    chk(w, 16'h0000);
    chk_in(v, 16'd20, 16'd23);
    idle_mode <= 1'b0;
    wr(GPT_OFS_PCNT, 16'h0000);
    wr(GPT_OFS_PCTL, 16'h8030);
    repeat (150) @(posedge mclk);
    wr(GPT_OFS_PCTL, 16'h8030);
    repeat (150) @(posedge mclk);
    wr(GPT_OFS_PCTL, 16'h0000);
    rd(GPT_OFS_PCNT, v);
    chk(v, 16'h0000);
    $display("idle and rewrite done");
    wr(GPT_OFS_OPER, 16'h0004);
    for (int p = 0; p < 2; p++) begin
      wr(GPT_OFS_OCTL, 16'h8000 | 16'(p << 4));
      gap(n);
      gap(n);
      chk(16'(n), 16'(5 * dv[p]));
      wr(GPT_OFS_OCTL, 16'h0000);
    end
    rd(GPT_OFS_FLAG, v);
    chk(v & 16'h0004, 16'h0004);
    wr(GPT_OFS_FLAG, 16'h0007);
    rd(GPT_OFS_FLAG, v);
    chk(v, 16'h0000);
    $display("match done");
    wr(GPT_OFS_ECTL, 16'h0008);
    wr(GPT_OFS_OCNT, 16'h0000);
    wr(GPT_OFS_ECNT, 16'hfff0);
    wr(GPT_OFS_OPER, 16'h0001);
    wr(GPT_OFS_EPER, 16'h0003);
    wr(GPT_OFS_OCTL, 16'h8030);
    wr(GPT_OFS_ECTL, 16'h8008);
    repeat (16) @(posedge mclk);
    wr(GPT_OFS_ECTL, 16'h0008);
    rd(GPT_OFS_OCNT, v);
    chk(v, 16'h0001);
    rd(GPT_OFS_ECNT, v);
    chk_in(v, 16'h0001, 16'h0003);
    wr(GPT_OFS_ECTL, 16'h8008);
    gap(n);
    chk_in(16'(n), 16'd1, 16'd4);
    rd(GPT_OFS_FLAG, v);
    chk(v & 16'h0006, 16'h0004);
    chk({15'h0, odd_flag}, 16'h0001);
    chk({15'h0, even_flag}, 16'h0000);
    wr(GPT_OFS_ECTL, 16'h0000);
    $display("wide done");
    sleep_mode <= 1'b1;
    clk_on <= 1'b1;
    wr(GPT_OFS_PCNT, 16'h0000);
    wr(GPT_OFS_PCTL, 16'h8002);
    repeat (100) @(posedge mclk);
    wr(GPT_OFS_PCTL, 16'h8006);
    rd(GPT_OFS_PCNT, w);
    repeat (50) @(posedge mclk);
    rd(GPT_OFS_PCNT, v);
    chk_in(w, 16'd16, 16'd22);
    chk(v, w);
    sleep_mode <= 1'b0;
    clk_on <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(GPT_OFS_FLAG, 16'h0007);
      wr(GPT_OFS_PCTL, i ? 16'h8042 : 16'h8040);
      level <= 1'b1;
      repeat (10) @(posedge mclk);
      level <= 1'b0;
      repeat (10) @(posedge mclk);
      rd(GPT_OFS_FLAG, v);
      chk(v & 16'h0001, i ? 16'h0000 : 16'h0001);
      chk({15'h0, primary_flag}, i ? 16'h0000 : 16'h0001);
    end
    $display("clock and gate done");
    report_and_stop();
  end
endmodule
